// *** bench/rtcsa_props.sv ***
// link checker: timing and ownership of the three-wire serial bus
`timescale 1ns/1ns
`default_nettype none
module rtcsa_props (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst_n,
   // link
   input wire logic cs,
   input wire logic sck,
   input wire logic host_sio_oe,
   input wire logic dev_sio_oe
);
   logic [4:0] rise_cnt_r;

   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_n);

   // ----------------------------------------
   // sck rises in the frame, saturating
   // ----------------------------------------
   always_ff @(posedge ref_clk or negedge rst_n)
      if (!rst_n)
         rise_cnt_r <= 5'h00;
      else if (!cs)
         rise_cnt_r <= 5'h00;
      else if ($rose(sck) && rise_cnt_r != 5'h1f)
         rise_cnt_r <= rise_cnt_r + 5'h01;

   // ----------------------------------------
   // assertions
   // ----------------------------------------
   a_sck_idle_high: assert property (!cs |-> sck)
      else $error("sck not high outside a frame");
   a_host_shift_fall: assert property ($changed(host_sio_oe) && cs |-> !sck)
      else $error("host changed data while sck high");
   a_sck_low_half: assert property ($fell(sck) |=> !sck [*8])
      else $error("sck low phase too short");
   a_sck_high_half: assert property ($rose(sck) && cs |=> sck [*8])
      else $error("sck high phase too short");
   a_host_in_frame: assert property (host_sio_oe |-> cs)
      else $error("host drives data outside a frame");
   a_no_fight: assert property (!(host_sio_oe && dev_sio_oe))
      else $error("host and device drive data together");
   a_cmd_silent: assert property (cs && $past(cs, 6) && rise_cnt_r < 5'h08 |-> !dev_sio_oe)
      else $error("device drives during the command byte");
   a_read_after_fall: assert property ($rose(dev_sio_oe) |-> !sck && cs)
      else $error("device read data not launched after a fall");
   a_cs_release: assert property ($fell(cs) |-> ##[0:5] !dev_sio_oe)
      else $error("device kept the data line after chip select fell");

   c_read_data: cover property ($rose(dev_sio_oe));
   c_one_byte: cover property ($fell(cs) && rise_cnt_r == 5'h10);
   c_three_byte: cover property ($fell(cs) && rise_cnt_r == 5'h1f);
endmodule
`default_nettype wire

// *** bench/rtcsa_tb_top.sv ***
// bench: host drives the device over the link; a bit-banged link feeds a second device
`timescale 1ns/1ns
`default_nettype none
module rtc_serial_access_and_trim_tb_top;
   typedef struct packed {logic [23:0] v; logic [23:0] m;} rtcsa_note_t;
   localparam logic [1:0] GS = rtcsa_pkg::GRP_STATUS;
   localparam logic [1:0] GE = rtcsa_pkg::GRP_SETTING;
   localparam logic [1:0] GT = rtcsa_pkg::GRP_TRIM;
   logic        ref_clk, busy, done, clk32k_pulse, alert_oe, freq_enable;
   logic        rst_n = 1'b0, rst_d = 1'b0, start = 1'b0, cmd_select = 1'b0, cmd_read = 1'b0;
   logic        osc_tick = 1'b0, tick_d = 1'b0, alarm1_match = 1'b0, alarm2_match = 1'b0;
   logic [1:0]  cmd_group = 2'h0, nbytes = 2'h0;
   logic [7:0]  freq_code, trim_word, trim2;
   logic [23:0] wdata = 24'h0, rdata;
   logic [7:0]  tv [5];
   int          err_total = 0, compares = 0, seed = 39;
   rtcsa_note_t q [$];
   rtcsa_note_t nt;

   rtcsa_if rtcsa_if_i ();
   rtcsa_if rtcsa_if_b_i ();
   rtcsa_host rtcsa_host_i (.ref_clk(ref_clk), .rst_n(rst_n), .link(rtcsa_if_i.host),
      .start(start), .cmd_group(cmd_group), .cmd_select(cmd_select), .cmd_read(cmd_read),
      .nbytes(nbytes), .wdata(wdata), .busy(busy), .done(done), .rdata(rdata));
   rtcsa_device rtcsa_device_i (.ref_clk(ref_clk), .rst_n(rst_n), .link(rtcsa_if_i.dev),
      .osc_tick(osc_tick), .alarm1_match(alarm1_match), .alarm2_match(alarm2_match),
      .clk32k_pulse(clk32k_pulse), .alert_o(), .alert_oe(alert_oe),
      .freq_enable(freq_enable), .freq_code(freq_code), .trim_word(trim_word));
   rtcsa_device rtcsa_device_b_i (.ref_clk(ref_clk), .rst_n(rst_n), .link(rtcsa_if_b_i.dev),
      .osc_tick(osc_tick), .alarm1_match(alarm1_match), .alarm2_match(alarm2_match),
      .clk32k_pulse(), .alert_o(), .alert_oe(), .freq_enable(), .freq_code(), .trim_word(trim2));
   rtcsa_props rtcsa_props_i (.ref_clk(ref_clk), .rst_n(rst_n), .cs(rtcsa_if_i.cs),
      .sck(rtcsa_if_i.sck), .host_sio_oe(rtcsa_if_i.host_sio_oe),
      .dev_sio_oe(rtcsa_if_i.dev_sio_oe));

   task automatic chk(input string nm, input logic [23:0] e, g);
      compares++;
      if (g !== e)
      begin
         err_total++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic conclude();
      $display("comparisons %0d mismatches %0d", compares, err_total);
      if (err_total == 0 && compares > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   // one host frame; the read mask keeps only the bytes that arrive
   task automatic xfer(input logic [1:0] g, input logic s, r, input logic [1:0] n,
                       input logic [23:0] w, e);
      int k;
      q.push_back({e, r ? 24'hffffff >> (8 * (3 - n)) : 24'h0});
      @(posedge ref_clk);
      cmd_group  <= g;
      cmd_select <= s;
      cmd_read   <= r;
      nbytes     <= n;
      wdata      <= w;
      start      <= 1'b1;
      @(posedge ref_clk);
      start <= 1'b0;
      @(posedge ref_clk);
      chk("busy", 24'h1, {23'h0, busy});
      for (k = 0; k < 2000 && done !== 1'b1; k++)
         @(posedge ref_clk);
      if (k == 2000)
         err_total++;
      chk("busy", 24'h0, {23'h0, busy});
   endtask

   // hand-made frame of n bits, cut short on purpose when n is small
   task automatic bang(input logic [15:0] b, input int n);
      rtcsa_if_b_i.cs <= 1'b1;
      for (int i = 0; i < n; i++)
      begin
         repeat (10) @(posedge ref_clk);
         rtcsa_if_b_i.sck         <= 1'b0;
         rtcsa_if_b_i.host_sio_oe <= ~b[15-i];
         repeat (10) @(posedge ref_clk);
         rtcsa_if_b_i.sck <= 1'b1;
      end
      repeat (10) @(posedge ref_clk);
      rtcsa_if_b_i.cs          <= 1'b0;
      rtcsa_if_b_i.host_sio_oe <= 1'b0;
      repeat (10) @(posedge ref_clk);
   endtask

   initial
   begin
      ref_clk = 1'b0;
      forever #4 ref_clk = ~ref_clk;
   end

   initial
   begin
      #400000;
      err_total++;
      conclude();
   end

   always @(posedge ref_clk)
      osc_tick <= 1'($random(seed));

   always @(posedge ref_clk)
   begin
      rst_d  <= rst_n;
      tick_d <= osc_tick;
      if (rst_d === 1'b1)
         chk("clk32k_pulse", {23'h0, tick_d}, {23'h0, clk32k_pulse});
      if (done === 1'b1 && q.size() > 0)
      begin
         nt = q.pop_front();
         if (nt.m != 24'h0)
            chk("rdata", nt.v, rdata & nt.m);
      end
   end

   initial
   begin
      rtcsa_if_b_i.cs          = 1'b0;
      rtcsa_if_b_i.sck         = 1'b1;
      rtcsa_if_b_i.host_sio_o  = 1'b0;
      rtcsa_if_b_i.host_sio_oe = 1'b0;
      repeat (6) @(posedge ref_clk);
      rst_n <= 1'b1;
      @(posedge ref_clk);
      chk("trim_word", 24'h0, {16'h0, trim_word});
      tv = '{8'h56, 8'hfc, 8'h03, 8'h00, 8'h00};
      tv[3] = 8'($random(seed));
      tv[4] = 8'($random(seed));
      foreach (tv[i])
      begin
         xfer(GT, 1'b0, 1'b0, 2'h1, {tv[i], 16'h0}, 24'h0);
         xfer(GT, 1'b0, 1'b1, 2'h1, 24'h0, {16'h0, tv[i]});
         chk("trim_word", {16'h0, tv[i]}, {16'h0, trim_word});
      end
      $display("trim test done");
      xfer(GS, 1'b0, 1'b0, 2'h1, 24'ha50000, 24'h0);
      xfer(GS, 1'b1, 1'b0, 2'h1, 24'h010000, 24'h0);
      xfer(GS, 1'b0, 1'b1, 2'h1, 24'h0, 24'h0000a5);
      xfer(GS, 1'b1, 1'b1, 2'h1, 24'h0, 24'h000001);
      xfer(GE, 1'b0, 1'b0, 2'h3, 24'h123456, 24'h0);
      xfer(GE, 1'b0, 1'b1, 2'h3, 24'h0, 24'h123456);
      xfer(GE, 1'b1, 1'b0, 2'h1, 24'h9a0000, 24'h0);
      xfer(GE, 1'b1, 1'b1, 2'h1, 24'h0, 24'h00009a);
      xfer(GS, 1'b1, 1'b0, 2'h1, 24'h040000, 24'h0);
      xfer(GE, 1'b1, 1'b0, 2'h3, 24'habcdef, 24'h0);
      xfer(GE, 1'b1, 1'b1, 2'h3, 24'h0, 24'habcdef);
      xfer(GS, 1'b1, 1'b0, 2'h1, 24'h020000, 24'h0);
      xfer(GE, 1'b0, 1'b0, 2'h1, 24'h5c0000, 24'h0);
      xfer(GE, 1'b1, 1'b0, 2'h1, 24'h770000, 24'h0);
      chk("freq_code", 24'h00005c, {16'h0, freq_code});
      chk("freq_enable", 24'h1, {23'h0, freq_enable});
      xfer(rtcsa_pkg::GRP_FREE, 1'b0, 1'b0, 2'h1, 24'h3c0000, 24'h0);
      xfer(rtcsa_pkg::GRP_FREE, 1'b0, 1'b1, 2'h1, 24'h0, 24'h00003c);
      $display("register select test done");
      for (int a = 0; a < 2; a++)
      begin
         xfer(GS, 1'b1, 1'b0, 2'h1, {(a == 1) ? 8'h04 : 8'h01, 16'h0}, 24'h0);
         alarm1_match <= (a == 0);
         alarm2_match <= (a == 1);
         @(posedge ref_clk);
         alarm1_match <= 1'b0;
         alarm2_match <= 1'b0;
         repeat (4) @(posedge ref_clk);
         chk("alert_oe", 24'h1, {23'h0, alert_oe});
         xfer(GS, 1'b1, 1'b0, 2'h1, 24'h0, 24'h0);
         repeat (4) @(posedge ref_clk);
         chk("alert_oe", 24'h0, {23'h0, alert_oe});
      end
      $display("alarm release test done");
      bang(16'h6856, 5);
      chk("trim_b", 24'h0, {16'h0, trim2});
      bang(16'h6856, 12);
      chk("trim_b", 24'h0, {16'h0, trim2});
      bang(16'h6856, 16);
      chk("trim_b", 24'h000056, {16'h0, trim2});
      // a command without the fixed code must name no register
      bang(16'h2833, 16);
      chk("trim_b", 24'h000056, {16'h0, trim2});
      $display("short frame test done");
      conclude();
   end
endmodule
`default_nettype wire

// *** hdl/rtcsa_device.sv ***
// rtc end: serial register access, setting registers and trim divider
`timescale 1ns/1ns
`default_nettype none
module rtcsa_device (
   // clock and reset
   input  wire logic       ref_clk,
   input  wire logic       rst_n,
   // serial link
   rtcsa_if.dev            link,
   // oscillator and alarm match events
   input  wire logic       osc_tick,
   input  wire logic       alarm1_match,
   input  wire logic       alarm2_match,
   // outputs
   output logic            clk32k_pulse,
   output logic            alert_o,
   output logic            alert_oe,
   output logic            freq_enable,
   output logic [7:0]      freq_code,
   output logic [7:0]      trim_word
);
   // ----------------------------------------------------------------------
   // pin synchronisation
   // ----------------------------------------------------------------------
   logic [2:0] pin_lvl;
   logic [2:0] pin_rise;
   logic [2:0] pin_fall;

   rtcsa_pin_sync #(.W(3)) u_sync (
      .ref_clk (ref_clk),
      .rst_n   (rst_n),
      .pin     ({link.serial_io_line, link.sck, link.cs}),
      .level   (pin_lvl),
      .rise    (pin_rise),
      .fall    (pin_fall)
   );

   wire cs_s     = pin_lvl[0];
   wire sck_rise = pin_rise[1] & cs_s;
   wire sck_fall = pin_fall[1] & cs_s;
   wire sio_s    = pin_lvl[2];

   // ----------------------------------------------------------------------
   // state and registers
   // ----------------------------------------------------------------------
   rtcsa_pkg::rtcsa_dev_state_t state_r;
   logic [2:0] bit_cnt_r;
   logic [1:0] byte_cnt_r;
   logic [7:0] sh_r;
   logic [1:0] grp_r;
   logic       sel_r;
   logic       sio_oe_r;
   logic [7:0] st1_r;
   logic [7:0] st2_r;
   logic [7:0] trim_r;
   logic [7:0] free_r;
   logic [7:0] set1_r [0:2];
   logic [7:0] set2_r [0:2];

   // ----------------------------------------------------------------------
   // command decode and register byte selection
   // ----------------------------------------------------------------------
   wire [7:0] in_byte   = {sh_r[6:0], sio_s};
   wire       byte_end  = bit_cnt_r == 3'h7;
   wire       code_ok   = in_byte[7:4] == rtcsa_pkg::CMD_FIXED_CODE;
   wire [1:0] cmd_grp   = in_byte[3:2];
   wire       cmd_sel   = in_byte[1];
   wire       cmd_rd    = in_byte[0];
   wire       alarm1_en = st2_r[rtcsa_pkg::ST2_ALARM1_EN];
   wire       alarm2_en = st2_r[rtcsa_pkg::ST2_ALARM2_EN];
   wire [1:0] len_set1  = alarm1_en ? rtcsa_pkg::LEN_ALARM : rtcsa_pkg::LEN_SINGLE;
   wire [1:0] len_set2  = alarm2_en ? rtcsa_pkg::LEN_ALARM : rtcsa_pkg::LEN_SINGLE;
   wire [1:0] len_cur   = (grp_r != rtcsa_pkg::GRP_SETTING) ? rtcsa_pkg::LEN_SINGLE :
                          (sel_r ? len_set2 : len_set1);
   wire [1:0] byte_nxt  = byte_cnt_r + 2'h1;

   function automatic logic [7:0] reg_byte(input logic [1:0] g, input logic s,
                                           input logic [1:0] idx);
      logic [1:0] i;
      i = (idx == 2'h3) ? 2'h2 : idx;
      case (g)
         rtcsa_pkg::GRP_STATUS:  reg_byte = s ? st2_r : st1_r;
         rtcsa_pkg::GRP_SETTING: reg_byte = s ? set2_r[i] : set1_r[i];
         rtcsa_pkg::GRP_TRIM:    reg_byte = trim_r;
         default:                reg_byte = free_r;
      endcase
   endfunction

   // ----------------------------------------------------------------------
   // serial engine
   // ----------------------------------------------------------------------
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state_r    <= rtcsa_pkg::DEV_CMD;
         bit_cnt_r  <= 3'h0;
         byte_cnt_r <= 2'h0;
         sh_r       <= 8'h00;
         grp_r      <= rtcsa_pkg::GRP_STATUS;
         sel_r      <= 1'b0;
         sio_oe_r   <= 1'b0;
      end
      else if (!cs_s)
      begin
         // a short frame drops only the byte in progress: bytes already completed stay stored, grp_r and sel_r keep their values
         state_r    <= rtcsa_pkg::DEV_CMD;
         bit_cnt_r  <= 3'h0;
         byte_cnt_r <= 2'h0;
         sio_oe_r   <= 1'b0;
      end
      else
      begin
         case (state_r)
            rtcsa_pkg::DEV_CMD:
               if (sck_rise)
               begin
                  sh_r      <= in_byte;
                  bit_cnt_r <= bit_cnt_r + 3'h1;
                  if (byte_end)
                  begin
                     grp_r      <= cmd_grp;
                     sel_r      <= cmd_sel;
                     byte_cnt_r <= 2'h0;
                     if (!code_ok)
                        state_r <= rtcsa_pkg::DEV_DONE;
                     else if (cmd_rd)
                     begin
                        state_r <= rtcsa_pkg::DEV_READ;
                        sh_r    <= reg_byte(cmd_grp, cmd_sel, 2'h0);
                     end
                     else
                        state_r <= rtcsa_pkg::DEV_WRITE;
                  end
               end
            rtcsa_pkg::DEV_READ:
               if (sck_fall)
               begin
                  if (byte_cnt_r < len_cur)
                  begin
                     sio_oe_r  <= ~sh_r[7];
                     bit_cnt_r <= bit_cnt_r + 3'h1;
                     sh_r      <= {sh_r[6:0], 1'b0};
                     if (byte_end)
                     begin
                        byte_cnt_r <= byte_nxt;
                        sh_r       <= reg_byte(grp_r, sel_r, byte_nxt);
                     end
                  end
                  else
                     sio_oe_r <= 1'b0;
               end
            rtcsa_pkg::DEV_WRITE:
               if (sck_rise)
               begin
                  sh_r      <= in_byte;
                  bit_cnt_r <= bit_cnt_r + 3'h1;
                  if (byte_end)
                  begin
                     byte_cnt_r <= byte_nxt;
                     if (byte_nxt == len_cur)
                        state_r <= rtcsa_pkg::DEV_DONE;
                  end
               end
            rtcsa_pkg::DEV_DONE:
               sio_oe_r <= 1'b0;
            default:
               state_r <= rtcsa_pkg::DEV_CMD;
         endcase
      end
   end

   // ----------------------------------------------------------------------
   // register file: a byte is stored only once all eight bits arrived
   // ----------------------------------------------------------------------
   wire wr_commit = cs_s & sck_rise & byte_end & (state_r == rtcsa_pkg::DEV_WRITE);
   wire wr_status = wr_commit & (grp_r == rtcsa_pkg::GRP_STATUS);
   wire wr_set    = wr_commit & (grp_r == rtcsa_pkg::GRP_SETTING);

   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         st1_r  <= rtcsa_pkg::ST1_RESET;
         st2_r  <= rtcsa_pkg::ST2_RESET;
         trim_r <= rtcsa_pkg::TRIM_RESET;
         free_r <= rtcsa_pkg::FREE_RESET;
         for (int k = 0; k < 3; k++)
         begin
            set1_r[k] <= rtcsa_pkg::SET_RESET;
            set2_r[k] <= rtcsa_pkg::SET_RESET;
         end
      end
      else
      begin
         if (wr_status && !sel_r)
            st1_r <= in_byte;
         if (wr_status && sel_r)
            st2_r <= in_byte;
         if (wr_set && !sel_r)
            set1_r[byte_cnt_r] <= in_byte;
         if (wr_set && sel_r)
            set2_r[byte_cnt_r] <= in_byte;
         if (wr_commit && grp_r == rtcsa_pkg::GRP_TRIM)
            trim_r <= in_byte;
         if (wr_commit && grp_r == rtcsa_pkg::GRP_FREE)
            free_r <= in_byte;
      end
   end

   // ----------------------------------------------------------------------
   // trim divider: only the count length of one second changes
   // ----------------------------------------------------------------------
   logic [16:0] tick_cnt_r;
   logic [5:0]  sec_idx_r;
   logic        onehz_r;
   logic        alarm1_flag_r;
   logic        alarm2_flag_r;
   logic        alert_oe_r;
   logic        clk32k_r;

   wire        fine_res   = trim_r[rtcsa_pkg::TRIM_RES_BIT];
   wire [6:0]  trim_steps = {trim_r[1], trim_r[2], trim_r[3], trim_r[4],
                             trim_r[5], trim_r[6], trim_r[7]};
   wire [16:0] trim_adj   = {{9{trim_steps[6]}}, trim_steps, 1'b0};
   wire [5:0]  period     = fine_res ? rtcsa_pkg::TRIM_PERIOD_FINE :
                                       rtcsa_pkg::TRIM_PERIOD_COARSE;
   wire        trim_sec   = sec_idx_r == (period - 6'h1);
   // a positive count shortens the corrected second, so the clock gains
   wire [16:0] sec_len    = trim_sec ? rtcsa_pkg::SECOND_TICKS - trim_adj
                                     : rtcsa_pkg::SECOND_TICKS;
   wire        sec_end    = osc_tick & (tick_cnt_r >= sec_len - 17'h1);

   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         tick_cnt_r <= 17'h00000;
         sec_idx_r  <= 6'h00;
         onehz_r    <= 1'b1;
      end
      else
      begin
         if (sec_end)
         begin
            tick_cnt_r <= 17'h00000;
            sec_idx_r  <= trim_sec ? 6'h00 : sec_idx_r + 6'h1;
         end
         else if (osc_tick)
            tick_cnt_r <= tick_cnt_r + 17'h1;
         onehz_r <= tick_cnt_r < {1'b0, sec_len[16:1]};
      end
   end

   // ----------------------------------------------------------------------
   // alert pin and oscillator output
   // ----------------------------------------------------------------------
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         alarm1_flag_r <= 1'b0;
         alarm2_flag_r <= 1'b0;
         alert_oe_r    <= 1'b0;
         clk32k_r      <= 1'b0;
      end
      else
      begin
         alarm1_flag_r <= alarm1_en & (alarm1_flag_r | alarm1_match);
         alarm2_flag_r <= alarm2_en & (alarm2_flag_r | alarm2_match);
         alert_oe_r    <= alarm1_flag_r | alarm2_flag_r |
                          (st2_r[rtcsa_pkg::ST2_ONEHZ_EN] & ~onehz_r);
         clk32k_r      <= osc_tick;
      end
   end

   assign link.dev_sio_o  = 1'b0;
   assign link.dev_sio_oe = sio_oe_r;
   assign alert_o         = 1'b0;
   assign alert_oe        = alert_oe_r;
   assign clk32k_pulse    = clk32k_r;
   assign freq_enable     = st2_r[rtcsa_pkg::ST2_FREQ_EN];
   assign freq_code       = set1_r[0];
   assign trim_word       = trim_r;
endmodule
`default_nettype wire

// *** hdl/rtcsa_host.sv ***
// host end: drives chip select and serial clock, shifts one command frame
`timescale 1ns/1ns
`default_nettype none
module rtcsa_host (
   // clock and reset
   input  wire logic        ref_clk,
   input  wire logic        rst_n,
   // serial link
   rtcsa_if.host            link,
   // request
   input  wire logic        start,
   input  wire logic [1:0]  cmd_group,
   input  wire logic        cmd_select,
   input  wire logic        cmd_read,
   input  wire logic [1:0]  nbytes,
   input  wire logic [23:0] wdata,
   // answer
   output logic             busy,
   output logic             done,
   output logic [23:0]      rdata
);
   rtcsa_pkg::rtcsa_host_state_t state_r;
   logic [4:0]  half_cnt_r;
   logic        sck_r;
   logic        cs_r;
   logic        oe_r;
   logic        rd_r;
   logic [31:0] tx_r;
   logic [23:0] rx_r;
   logic [23:0] rdata_r;
   logic [5:0]  sent_r;
   logic [5:0]  total_r;
   logic        done_r;
   logic        sio_s;

   rtcsa_pin_sync #(.W(1)) u_sync (
      .ref_clk (ref_clk),
      .rst_n   (rst_n),
      .pin     (link.serial_io_line),
      .level   (sio_s),
      .rise    (),
      .fall    ()
   );

   wire half_tick = half_cnt_r == rtcsa_pkg::HOST_HALF_LAST;
   wire data_ph   = sent_r >= 6'h08;

   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state_r    <= rtcsa_pkg::HOST_IDLE;
         half_cnt_r <= 5'h00;
         sck_r      <= 1'b1;
         cs_r       <= 1'b0;
         oe_r       <= 1'b0;
         rd_r       <= 1'b0;
         tx_r       <= 32'h00000000;
         rx_r       <= 24'h000000;
         rdata_r    <= 24'h000000;
         sent_r     <= 6'h00;
         total_r    <= 6'h00;
         done_r     <= 1'b0;
      end
      else
      begin
         done_r     <= 1'b0;
         half_cnt_r <= (half_tick || state_r == rtcsa_pkg::HOST_IDLE) ? 5'h00
                                                                        : half_cnt_r + 5'h1;
         case (state_r)
            rtcsa_pkg::HOST_IDLE:
               if (start)
               begin
                  cs_r    <= 1'b1;
                  sck_r   <= 1'b1;
                  rd_r    <= cmd_read;
                  tx_r    <= {rtcsa_pkg::CMD_FIXED_CODE, cmd_group, cmd_select, cmd_read, wdata};
                  sent_r  <= 6'h00;
                  total_r <= {1'b0, nbytes, 3'h0} + 6'h08;
                  state_r <= rtcsa_pkg::HOST_LEAD;
               end
            rtcsa_pkg::HOST_LEAD:
               if (half_tick)
                  state_r <= rtcsa_pkg::HOST_CLK;
            rtcsa_pkg::HOST_CLK:
               if (half_tick && sck_r)
               begin
                  // data changes in the same cycle as the falling edge
                  sck_r <= 1'b0;
                  oe_r  <= (!data_ph || !rd_r) & ~tx_r[31];
                  tx_r  <= {tx_r[30:0], 1'b0};
               end
               else if (half_tick)
               begin
                  sck_r  <= 1'b1;
                  sent_r <= sent_r + 6'h1;
                  if (rd_r && data_ph)
                     rx_r <= {rx_r[22:0], sio_s};
                  if (sent_r + 6'h1 == total_r)
                     state_r <= rtcsa_pkg::HOST_TAIL;
               end
            rtcsa_pkg::HOST_TAIL:
               if (half_tick)
               begin
                  cs_r    <= 1'b0;
                  oe_r    <= 1'b0;
                  done_r  <= 1'b1;
                  rdata_r <= rx_r;
                  state_r <= rtcsa_pkg::HOST_IDLE;
               end
            default:
               state_r <= rtcsa_pkg::HOST_IDLE;
         endcase
      end
   end

   assign link.cs          = cs_r;
   assign link.sck         = sck_r;
   assign link.host_sio_o  = 1'b0;
   assign link.host_sio_oe = oe_r;
   assign busy             = state_r != rtcsa_pkg::HOST_IDLE;
   assign done             = done_r;
   assign rdata            = rdata_r;
endmodule
`default_nettype wire

// *** hdl/rtcsa_if.sv ***
// three-wire link between host and rtc, with open-drain data line
`timescale 1ns/1ns
`default_nettype none
interface rtcsa_if;
   logic cs;
   logic sck;
   logic host_sio_o;
   logic host_sio_oe;
   logic dev_sio_o;
   logic dev_sio_oe;
   wire  serial_io_line;

   // open drain with pull-up: any enabled low driver wins
   assign serial_io_line = ~((host_sio_oe & ~host_sio_o) | (dev_sio_oe & ~dev_sio_o));

   modport dev  (input cs, sck, serial_io_line, output dev_sio_o, dev_sio_oe);
   modport host (output cs, sck, host_sio_o, host_sio_oe, input serial_io_line);
endinterface
`default_nettype wire

// *** hdl/rtcsa_pin_sync.sv ***
// two-flop synchroniser with edge detection for pins from outside the domain
`timescale 1ns/1ns
`default_nettype none
module rtcsa_pin_sync #(
   parameter int W = 1
) (
   // clock and reset
   input  wire logic         ref_clk,
   input  wire logic         rst_n,
   // pins and synchronised view
   input  wire logic [W-1:0] pin,
   output logic      [W-1:0] level,
   output logic      [W-1:0] rise,
   output logic      [W-1:0] fall
);
   logic [W-1:0] meta_r;
   logic [W-1:0] sync_r;
   logic [W-1:0] prev_r;

   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         meta_r <= '0;
         sync_r <= '0;
         prev_r <= '0;
      end
      else
      begin
         meta_r <= pin;
         sync_r <= meta_r;
         prev_r <= sync_r;
      end
   end

   assign level = sync_r;
   assign rise  = sync_r & ~prev_r;
   assign fall  = ~sync_r & prev_r;
endmodule
`default_nettype wire

// *** hdl/rtcsa_pkg.sv ***
// constants and types shared by both ends of the rtc serial access link
package rtcsa_pkg;

   // ----------------------------------------------------------------------
   // command byte: fixed code, register group, select bit, direction bit
   // ----------------------------------------------------------------------
   localparam logic [3:0] CMD_FIXED_CODE = 4'h6;
   localparam logic [1:0] GRP_STATUS     = 2'h0;
   localparam logic [1:0] GRP_SETTING    = 2'h1;
   localparam logic [1:0] GRP_TRIM       = 2'h2;
   localparam logic [1:0] GRP_FREE       = 2'h3;

   // ----------------------------------------------------------------------
   // status register 2 and trim field positions, register reset values and data byte counts
   // ----------------------------------------------------------------------
   localparam int         ST2_ALARM1_EN  = 0;
   localparam int         ST2_FREQ_EN    = 1;
   localparam int         ST2_ALARM2_EN  = 2;
   localparam int         ST2_ONEHZ_EN   = 3;
   localparam int         TRIM_RES_BIT   = 0;
   localparam logic [7:0] ST1_RESET      = 8'h00;
   localparam logic [7:0] ST2_RESET      = 8'h08;
   localparam logic [7:0] TRIM_RESET     = 8'h00;
   localparam logic [7:0] SET_RESET      = 8'h00;
   localparam logic [7:0] FREE_RESET     = 8'h00;
   localparam logic [1:0] LEN_ALARM      = 2'h3;
   localparam logic [1:0] LEN_SINGLE     = 2'h1;

   // ----------------------------------------------------------------------
   // trim divider, counted in oscillator ticks and seconds
   // ----------------------------------------------------------------------
   localparam logic [16:0] SECOND_TICKS  = 17'h08000;
   localparam logic [5:0]  TRIM_PERIOD_COARSE = 6'h14;
   localparam logic [5:0]  TRIM_PERIOD_FINE   = 6'h3c;

   // ----------------------------------------------------------------------
   // host serial clock, derived from ref_clk
   // ----------------------------------------------------------------------
   localparam int         CLK_PERIOD_NS      = 8;
   localparam int         HOST_SCK_PERIOD_NS = 160;
   localparam int         HOST_HALF_CYCLES   = HOST_SCK_PERIOD_NS / (2 * CLK_PERIOD_NS);
   localparam logic [4:0] HOST_HALF_LAST     = 5'(HOST_HALF_CYCLES - 1);

   typedef enum logic [1:0] {
      DEV_CMD   = 2'b00,
      DEV_WRITE = 2'b01,
      DEV_READ  = 2'b10,
      DEV_DONE  = 2'b11
   } rtcsa_dev_state_t;

   typedef enum logic [1:0] {
      HOST_IDLE = 2'b00,
      HOST_LEAD = 2'b01,
      HOST_CLK  = 2'b10,
      HOST_TAIL = 2'b11
   } rtcsa_host_state_t;

endpackage
